//--- tb/adtc_core_model.sv
// adtc_core_model.sv: analogue core and touch panel seen by the block
module adtc_core_model (
	// controls from the block
	input  wire logic       core_standby,
	input  wire logic [2:0] analogue_input,
	input  wire logic       xplus_switch_n,
	input  wire logic       xminus_switch,
	input  wire logic       yplus_switch_n,
	input  wire logic       yminus_switch,
	input  wire logic       xplus_pullup_n,
	// stylus position and contact from the bench
	input  wire logic       pen_down,
	input  wire logic [9:0] x_code,
	input  wire logic [9:0] y_code,
	// answers to the block
	output logic [9:0]      core_data,
	output logic            pen_level
);
	timeunit 1ns;
	timeprecision 1ns;

	//----------------------------------------------------------
	// divider voltage picked by the switch pattern
	//----------------------------------------------------------
	// a core held in standby gives no valid code, so show a wrong one
	always_comb begin
		if (core_standby) begin
			core_data = ~x_code;
		end else if (!xplus_switch_n && xminus_switch) begin
			core_data = x_code;
		end else if (!yplus_switch_n && yminus_switch &&
			analogue_input == 3'h7) begin
			core_data = y_code;
		end else begin
			core_data = {analogue_input, 7'h35};
		end
	end

	// comparator sees contact only with pull-up on and y-minus grounded
	assign pen_level = pen_down && !xplus_pullup_n && yminus_switch;
endmodule

//--- tb/tb.sv
// tb.sv: register-level bench for the converter and touch controller
`include "adtc_params.svh"
`define CHK(got, exp) begin \
	check_count++; \
	if ((got) !== (exp)) begin \
		n_errors++; \
		$display("BAD %0t got %0h want %0h", $time, got, exp); \
	end \
end
module tb;
	timeunit 1ns;
	timeprecision 1ns;

	//----------------------------------------------------------
	// signals
	//----------------------------------------------------------
	logic        clk, rst, ce, wr, rd, pen_down, pen_level;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata, d;
	logic [9:0]  core_data, x_code, y_code;
	logic [2:0]  analogue_input, ch_cap;
	logic [3:0]  sw_cap;
	logic        core_clk, core_start, core_standby, xplus_pullup_n;
	logic        xplus_switch_n, xminus_switch;
	logic        yplus_switch_n, yminus_switch;
	logic        touch_conversion_irq, stylus_irq, tc_q, sty_q, st_q;
	int          n_errors, check_count, tc_cnt, sty_cnt, st_cnt;
	int          gap, gap_run, tk, tk_irq, tc_base, n;
	// n=39 keeps the converter clock at 2.5 MHz from 100 MHz
	localparam logic [15:0] PRS = 16'h49C0;

	adtc_top i_adtc_top (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.core_data(core_data), .core_clk(core_clk),
		.core_start(core_start), .analogue_input(analogue_input),
		.core_standby(core_standby), .pen_level(pen_level),
		.xplus_switch_n(xplus_switch_n), .xminus_switch(xminus_switch),
		.yplus_switch_n(yplus_switch_n), .yminus_switch(yminus_switch),
		.xplus_pullup_n(xplus_pullup_n),
		.touch_conversion_irq(touch_conversion_irq),
		.stylus_irq(stylus_irq));

	adtc_core_model i_adtc_core_model (.core_standby(core_standby),
		.analogue_input(analogue_input), .xplus_switch_n(xplus_switch_n),
		.xminus_switch(xminus_switch), .yplus_switch_n(yplus_switch_n),
		.yminus_switch(yminus_switch), .xplus_pullup_n(xplus_pullup_n),
		.pen_down(pen_down), .x_code(x_code), .y_code(y_code),
		.core_data(core_data), .pen_level(pen_level));

	always #5 clk = ~clk;

	//----------------------------------------------------------
	// monitor: event counts, tick gap, switch pattern at start
	//----------------------------------------------------------
	// sampled on the falling edge, away from the edge that moves outputs;
	// ticks count from the cycle after the start pulse, as the timer does
	always @(negedge clk) begin
		if (touch_conversion_irq === 1'b1) begin
			`CHK(tc_q, 1'b0)
			tc_cnt++;
			tk_irq = tk;
		end
		if (stylus_irq === 1'b1) begin
			`CHK(sty_q, 1'b0)
			sty_cnt++;
		end
		tc_q = touch_conversion_irq;
		sty_q = stylus_irq;
		gap_run++;
		if (core_start === 1'b1) begin
			st_cnt++;
			sw_cap = {xplus_switch_n, xminus_switch,
				yplus_switch_n, yminus_switch};
			ch_cap = analogue_input;
		end
		// a tick beside the start pulse is lost by the timer, so skip it
		if (st_q === 1'b1) begin
			tk = 0;
		end else if (core_clk === 1'b1) begin
			tk++;
		end
		st_q = core_start;
		if (core_clk === 1'b1) begin
			gap = gap_run;
			gap_run = 0;
		end
	end

	//----------------------------------------------------------
	// register port tasks
	//----------------------------------------------------------
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic expect_rd(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd_reg(a, v);
		`CHK(v, e)
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic fail_wait(input logic ok);
		if (!ok) begin
			n_errors++;
			$display("BAD %0t wait ran out", $time);
			close_out();
		end
	endtask

	// polls the end flag only; the auto test waits for the final irq itself
	task automatic wait_done();
		logic [31:0] v;
		v = 32'h0;
		for (int i = 0; i < 400 && v[15] !== 1'b1; i++)
			rd_reg(`ADTC_OFF_CTRL, v);
		fail_wait(v[15] === 1'b1);
	endtask

	task automatic convert(input logic [31:0] t, input logic [15:0] c);
		wr_reg(`ADTC_OFF_TOUCH, t);
		tc_base = tc_cnt;
		wr_reg(`ADTC_OFF_CTRL, {16'h0, PRS | c});
		wait_done();
	endtask

	//----------------------------------------------------------
	// main sequence
	//----------------------------------------------------------
	initial begin
		{clk, wr, rd, pen_down, tc_q, sty_q, st_q} = '0;
		{addr, wdata, sw_cap, ch_cap} = '0;
		{n_errors, check_count, tc_cnt, sty_cnt, st_cnt} = '0;
		{gap, gap_run, tk, tk_irq} = '0;
		ce = 1'b1;
		rst = 1'b1;
		x_code = 10'h2A5;
		y_code = 10'h15A;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 `CHK(core_standby, 1'b1)
		`CHK({xplus_switch_n, xminus_switch, yplus_switch_n,
			yminus_switch, xplus_pullup_n}, 5'h15)
		expect_rd(`ADTC_OFF_CTRL, 32'h0000_3FC4);
		expect_rd(`ADTC_OFF_TOUCH, 32'h0000_0058);
		expect_rd(4'h2, 32'h0000_0000);
		wr_reg(`ADTC_OFF_TOUCH, 32'h0000_00A0);
		repeat (2) @(posedge clk);
		#1 `CHK({xplus_switch_n, xminus_switch, yplus_switch_n,
			yminus_switch, xplus_pullup_n}, 5'h0A)
		$display("test reset and switch bits done");

		convert(32'h0000_0058, 16'h0019);
		`CHK(ch_cap, 3'h3)
		`CHK(gap, 40)
		`CHK(tc_cnt, tc_base)
		expect_rd(`ADTC_OFF_DATA0, 32'h0000_01B5);
		expect_rd(`ADTC_OFF_CTRL, 32'h0000_C9D8);
		$display("test normal conversion done");

		// host flow: wait, stylus irq, convert x and y, wait again
		wr_reg(`ADTC_OFF_TOUCH, 32'h0000_0093);
		repeat (3) @(posedge clk);
		#1 `CHK({xplus_switch_n, xminus_switch, yplus_switch_n,
			yminus_switch, xplus_pullup_n}, 5'h16)
		n = sty_cnt;
		pen_down <= 1'b1;
		repeat (8) @(posedge clk);
		`CHK(sty_cnt, n + 1)
		convert(32'h0000_0059, 16'h0001);
		`CHK(sw_cap, 4'b0110)
		`CHK(tk_irq, 5)
		`CHK(tc_cnt, tc_base + 1)
		expect_rd(`ADTC_OFF_DATA0, 32'h0000_02A5);
		convert(32'h0000_005A, 16'h0001);
		`CHK(sw_cap, 4'b1001)
		`CHK(ch_cap, 3'h7)
		`CHK(tc_cnt, tc_base + 1)
		expect_rd(`ADTC_OFF_DATA1, 32'h0000_015A);
		wr_reg(`ADTC_OFF_TOUCH, 32'h0000_0193);
		repeat (8) @(posedge clk);
		n = sty_cnt;
		pen_down <= 1'b0;
		repeat (8) @(posedge clk);
		`CHK(sty_cnt, n + 1)
		$display("test stylus and separate conversions done");

		x_code = 10'h1C3;
		y_code = 10'h0E7;
		convert(32'h0000_005C, 16'h0001);
		for (int i = 0; i < 600 && tc_cnt == tc_base; i++)
			@(posedge clk);
		fail_wait(tc_cnt != tc_base);
		repeat (4) @(posedge clk);
		`CHK(tc_cnt, tc_base + 1)
		expect_rd(`ADTC_OFF_DATA0, 32'h0000_01C3);
		expect_rd(`ADTC_OFF_DATA1, 32'h0000_00E7);
		$display("test auto sequence done");

		x_code = 10'h0F0;
		wr_reg(`ADTC_OFF_TOUCH, 32'h0000_0059);
		n = st_cnt;
		wr_reg(`ADTC_OFF_CTRL, {16'h0, PRS | 16'h0003});
		repeat (20) @(posedge clk);
		`CHK(st_cnt, n)
		rd_reg(`ADTC_OFF_DATA0, d);
		wait_done();
		`CHK(st_cnt, n + 1)
		expect_rd(`ADTC_OFF_DATA0, 32'h0000_00F0);
		$display("test start on read done");

		wr_reg(`ADTC_OFF_CTRL, {16'h0, PRS | 16'h0005});
		x_code = 10'h333;
		n = st_cnt;
		repeat (400) @(posedge clk);
		`CHK(st_cnt, n)
		`CHK(core_standby, 1'b1)
		expect_rd(`ADTC_OFF_DATA0, 32'h0000_00F0);
		expect_rd(`ADTC_OFF_DATA1, 32'h0000_00E7);
		$display("test standby done");
		close_out();
	end
endmodule

//--- verilog/adtc_clkdiv.sv
// adtc_clkdiv.sv: prescaler making the converter clock tick
`include "adtc_params.svh"
module adtc_clkdiv (
	// clock and control
	input  logic       clk,
	input  logic       rst,
	input  logic       ce,
	// prescaler setting
	input  logic       enable,
	input  logic [7:0] div,
	// one-cycle tick every div+1 cycles
	output logic       tick
);
	adtc_pkg::adtc_div_s r, n;

	// count 0..div, tick on wrap; held at zero when disabled
	always_comb begin
		n = r;
		n.tick = 1'b0;
		if (!enable) begin
			n.cnt = 8'h00;
		end else if (r.cnt >= div) begin
			n.cnt = 8'h00;
			n.tick = 1'b1;
		end else begin
			n.cnt = r.cnt + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) r <= '0;
		else if (ce) r <= n;
	end

	assign tick = r.tick;

	tick_gap_a: assert property (@(posedge clk) disable iff (rst)
		(ce && tick && div != 8'h00) |=> !tick) else $error("tick too close");
	div_off_a: assert property (@(posedge clk) disable iff (rst)
		(ce && !enable) |=> !tick) else $error("tick while disabled");
endmodule

//--- verilog/adtc_conv.sv
// adtc_conv.sv: conversion timer and result capture
`include "adtc_params.svh"
module adtc_conv (
	// clock and control
	input  logic             clk,
	input  logic             rst,
	input  logic             ce,
	// code from the analogue core
	input  logic [9:0]       core_data,
	// sequencer side
	adtc_conv_if.seq         cv
);
	adtc_pkg::adtc_conv_s r, n;

	// core code is synchronised before capture; it settles long before
	// the fifth converter clock so two stages cost nothing
	always_comb begin
		n = r;
		n.done = 1'b0;
		n.s0 = core_data;
		n.s1 = r.s0;
		if (cv.abort) begin
			n.busy = 1'b0;
			n.cnt = 3'h0;
		end else if (cv.start) begin
			n.busy = 1'b1;
			n.cnt = 3'h0;
		end else if (r.busy && cv.tick) begin
			if (r.cnt == `ADTC_CONV_LAST) begin
				n.busy = 1'b0;
				n.done = 1'b1;
				n.result = r.s1;
			end else begin
				n.cnt = r.cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) r <= '0;
		else if (ce) r <= n;
	end

	assign cv.busy = r.busy;
	assign cv.done = r.done;
	assign cv.result = r.result;

	conv_length_a: assert property (@(posedge clk) disable iff (rst)
		(ce && r.busy && cv.tick && r.cnt == `ADTC_CONV_LAST
		&& !cv.abort && !cv.start) |=> (cv.done && !cv.busy))
		else $error("conversion did not end on fifth clock");
endmodule

//--- verilog/adtc_conv_if.sv
// adtc_conv_if.sv: link between sequencer and conversion timer
interface adtc_conv_if;
	logic       start;
	logic       abort;
	logic       tick;
	logic       busy;
	logic       done;
	logic [9:0] result;
	modport ctl (output start, abort, tick, input busy, done, result);
	modport seq (input start, abort, tick, output busy, done, result);
endinterface

//--- verilog/adtc_params.svh
// adtc_params.svh: offsets, field positions, reset values and timing
`ifndef ADTC_PARAMS_SVH
`define ADTC_PARAMS_SVH
// register byte offsets
`define ADTC_OFF_CTRL   4'h0
`define ADTC_OFF_TOUCH  4'h4
`define ADTC_OFF_DATA0  4'h8
`define ADTC_OFF_DATA1  4'hC
// reset values
`define ADTC_CTRL_RST   16'h3FC4
`define ADTC_TOUCH_RST  9'h058
// converter control fields
`define ADTC_EOC        15
`define ADTC_PRSCEN     14
`define ADTC_PRSC       13:6
`define ADTC_SEL        5:3
`define ADTC_STANDBY_SELECT      2
`define ADTC_RDSTART    1
`define ADTC_START      0
// touch control fields
`define ADTC_UD         8
`define ADTC_YM         7
`define ADTC_YP         6
`define ADTC_XM         5
`define ADTC_XP         4
`define ADTC_PULL       3
`define ADTC_AUTO       2
`define ADTC_POS        1:0
// position select codes
`define ADTC_POS_NORM   2'h0
`define ADTC_POS_X      2'h1
`define ADTC_POS_Y      2'h2
`define ADTC_POS_WAIT   2'h3
// five converter clocks per result, counted 0..4
`define ADTC_CONV_LAST  3'h4
`define ADTC_XP_CHAN    3'h7
`endif

//--- verilog/adtc_pkg.sv
// adtc_pkg.sv: state and struct types of the converter controller
package adtc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_NORM, ST_XS, ST_YS, ST_AX, ST_AY
	} adtc_state_e;

	typedef struct packed {
		logic [15:0] ctrl;
		logic [8:0]  touch;
		logic [9:0]  x_res;
		logic [9:0]  y_res;
		adtc_state_e state;
		logic        rd_pend;
		logic [31:0] rdata;
		logic [2:0]  pen_sync;
		logic        conv_start;
		logic        core_clk;
		logic [2:0]  chan;
		logic        xp_n;
		logic        xm;
		logic        yp_n;
		logic        ym;
		logic        pull_n;
		logic        standby;
		logic        tc_irq;
		logic        sty_irq;
	} adtc_top_s;

	typedef struct packed {
		logic [2:0] cnt;
		logic       busy;
		logic       done;
		logic [9:0] s0;
		logic [9:0] s1;
		logic [9:0] result;
	} adtc_conv_s;

	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} adtc_div_s;
endpackage

//--- verilog/adtc_top.sv
// adtc_top.sv: converter and touch panel control with register port
//
// Decided for this implementation: strobed register access and the register addresses.
`include "adtc_params.svh"
//------------------------------------------------------------------
//------------------------------------------------------------------
module adtc_top (
	// clock, reset, enable
	input  logic        clk,
	input  logic        rst,
	input  logic        ce,
	// register port
	input  logic [3:0]  addr,
	input  logic [31:0] wdata,
	input  logic        wr,
	input  logic        rd,
	output logic [31:0] rdata,
	// analogue core
	input  logic [9:0]  core_data,
	output logic        core_clk,
	output logic        core_start,
	output logic [2:0]  analogue_input,
	output logic        core_standby,
	// touch panel
	input  logic        pen_level,
	output logic        xplus_switch_n,
	output logic        xminus_switch,
	output logic        yplus_switch_n,
	output logic        yminus_switch,
	output logic        xplus_pullup_n,
	// interrupt pulses
	output logic        touch_conversion_irq,
	output logic        stylus_irq
);

	//--------------------------------------------------------------
	// sub blocks
	//--------------------------------------------------------------
	adtc_pkg::adtc_top_s r, n;
	logic                div_tick;
	logic                go;
	logic                wait_md;
	logic                y_phase;
	logic                x_phase;

	adtc_conv_if cv ();

	// prescaler only runs while enabled, so a disabled one stalls work
	adtc_clkdiv u_div (
		.clk    (clk),
		.rst    (rst),
		.ce     (ce),
		.enable (r.ctrl[`ADTC_PRSCEN]),
		.div    (r.ctrl[`ADTC_PRSC]),
		.tick   (div_tick)
	);

	adtc_conv u_conv (
		.clk       (clk),
		.rst       (rst),
		.ce        (ce),
		.core_data (core_data),
		.cv        (cv.seq)
	);

	// timer control from registered state
	assign cv.start = r.conv_start;
	assign cv.abort = r.ctrl[`ADTC_STANDBY_SELECT];
	assign cv.tick = div_tick;

	//--------------------------------------------------------------
	// decode helpers
	//--------------------------------------------------------------
	// software start is void while start-on-read is on
	assign go = (r.ctrl[`ADTC_START] & ~r.ctrl[`ADTC_RDSTART])
		| r.rd_pend;
	assign wait_md = r.touch[`ADTC_YM] & r.touch[`ADTC_XP]
		& (r.touch[`ADTC_POS] == `ADTC_POS_WAIT);

	//--------------------------------------------------------------
	// next state
	//--------------------------------------------------------------
	always_comb begin
		n = r;
		x_phase = 1'b0;
		y_phase = 1'b0;
		n.tc_irq = 1'b0;
		n.sty_irq = 1'b0;
		n.conv_start = 1'b0;
		n.rdata = 32'h0000_0000;
		n.pen_sync = {r.pen_sync[1:0], pen_level};

		// sequencer; standby drops any conversion in flight
		if (r.ctrl[`ADTC_STANDBY_SELECT] && r.state != adtc_pkg::ST_IDLE) begin
			n.state = adtc_pkg::ST_IDLE;
		end else begin
			case (r.state)
			adtc_pkg::ST_IDLE: begin
				if (go && !r.ctrl[`ADTC_STANDBY_SELECT]) begin
					n.ctrl[`ADTC_START] = 1'b0;
					n.rd_pend = 1'b0;
					if (r.touch[`ADTC_AUTO]) begin
						n.state = adtc_pkg::ST_AX;
					end else begin
						case (r.touch[`ADTC_POS])
						`ADTC_POS_NORM: n.state = adtc_pkg::ST_NORM;
						`ADTC_POS_X: n.state = adtc_pkg::ST_XS;
						`ADTC_POS_Y: n.state = adtc_pkg::ST_YS;
						default: n.state = adtc_pkg::ST_IDLE;
						endcase
					end
					if (n.state != adtc_pkg::ST_IDLE) begin
						n.conv_start = 1'b1;
						n.ctrl[`ADTC_EOC] = 1'b0;
					end
				end
			end
			adtc_pkg::ST_NORM, adtc_pkg::ST_XS: begin
				if (cv.done) begin
					n.x_res = cv.result;
					n.ctrl[`ADTC_EOC] = 1'b1;
					n.tc_irq = (r.state == adtc_pkg::ST_XS);
					n.state = adtc_pkg::ST_IDLE;
				end
			end
			adtc_pkg::ST_YS: begin
				if (cv.done) begin
					n.y_res = cv.result;
					n.ctrl[`ADTC_EOC] = 1'b1;
					n.tc_irq = 1'b1;
					n.state = adtc_pkg::ST_IDLE;
				end
			end
			adtc_pkg::ST_AX: begin
				// x stored, y launched at once, no irq in between
				if (cv.done) begin
					n.x_res = cv.result;
					n.conv_start = 1'b1;
					n.state = adtc_pkg::ST_AY;
				end
			end
			adtc_pkg::ST_AY: begin
				if (cv.done) begin
					n.y_res = cv.result;
					n.ctrl[`ADTC_EOC] = 1'b1;
					n.tc_irq = 1'b1;
					n.state = adtc_pkg::ST_IDLE;
				end
			end
			default: n.state = adtc_pkg::ST_IDLE;
			endcase
		end

		// stylus edge from the synchronised pen level, second stage on
		if (wait_md) begin
			if (r.touch[`ADTC_UD]) begin
				n.sty_irq = ~r.pen_sync[1] & r.pen_sync[2];
			end else begin
				n.sty_irq = r.pen_sync[1] & ~r.pen_sync[2];
			end
		end

		// register writes; end-of-conversion flag is read only
		if (wr) begin
			case (addr)
			`ADTC_OFF_CTRL: n.ctrl = {n.ctrl[`ADTC_EOC], wdata[14:0]};
			`ADTC_OFF_TOUCH: n.touch = wdata[8:0];
			default: n.touch = n.touch;
			endcase
		end

		// reads answer in the next cycle; unmapped reads give zero
		if (rd) begin
			case (addr)
			`ADTC_OFF_CTRL: n.rdata = {16'h0000, r.ctrl};
			`ADTC_OFF_TOUCH: n.rdata = {23'h00_0000, r.touch};
			`ADTC_OFF_DATA0: n.rdata = {22'h00_0000, r.x_res};
			`ADTC_OFF_DATA1: n.rdata = {22'h00_0000, r.y_res};
			default: n.rdata = 32'h0000_0000;
			endcase
			if (r.ctrl[`ADTC_RDSTART] && (addr == `ADTC_OFF_DATA0
				|| addr == `ADTC_OFF_DATA1)) begin
				n.rd_pend = 1'b1;
			end
		end

		// panel switches follow the phase being entered
		x_phase = (n.state == adtc_pkg::ST_XS)
			|| (n.state == adtc_pkg::ST_AX);
		y_phase = (n.state == adtc_pkg::ST_YS)
			|| (n.state == adtc_pkg::ST_AY);
		n.xp_n = r.touch[`ADTC_XP];
		n.xm = r.touch[`ADTC_XM];
		n.yp_n = r.touch[`ADTC_YP];
		n.ym = r.touch[`ADTC_YM];
		n.pull_n = r.touch[`ADTC_PULL];
		if (x_phase) begin
			{n.xp_n, n.xm, n.yp_n, n.ym} = 4'b0110;
		end else if (y_phase) begin
			{n.xp_n, n.xm, n.yp_n, n.ym} = 4'b1001;
		end else if (wait_md) begin
			{n.xp_n, n.xm, n.yp_n, n.ym} = 4'b1011;
			n.pull_n = 1'b0;
		end
		// y is sensed on the x-plus input
		n.chan = y_phase ? `ADTC_XP_CHAN : r.ctrl[`ADTC_SEL];
		n.core_clk = div_tick;
		n.standby = n.ctrl[`ADTC_STANDBY_SELECT];
	end

	//--------------------------------------------------------------
	// state register
	//--------------------------------------------------------------
	// clock enable freezes everything, including the synchroniser
	always_ff @(posedge clk) begin
		if (rst) begin
			r <= '0;
			r.ctrl <= `ADTC_CTRL_RST;
			r.touch <= `ADTC_TOUCH_RST;
			r.xp_n <= 1'b1;
			r.yp_n <= 1'b1;
			r.pull_n <= 1'b1;
			r.standby <= 1'b1;
		end else if (ce) begin
			r <= n;
		end
	end

	// outputs straight from flops
	assign rdata = r.rdata;
	assign core_clk = r.core_clk;
	assign core_start = r.conv_start;
	assign analogue_input = r.chan;
	assign core_standby = r.standby;
	assign xplus_switch_n = r.xp_n;
	assign xminus_switch = r.xm;
	assign yplus_switch_n = r.yp_n;
	assign yminus_switch = r.ym;
	assign xplus_pullup_n = r.pull_n;
	assign touch_conversion_irq = r.tc_irq;
	assign stylus_irq = r.sty_irq;

	//--------------------------------------------------------------
	// checks
	//--------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	eoc_set_a: assert property (
		(ce && !r.ctrl[`ADTC_STANDBY_SELECT] && r.state == adtc_pkg::ST_NORM
		&& cv.done) |=> (r.ctrl[`ADTC_EOC] && !touch_conversion_irq))
		else $error("normal conversion end missing");
	x_store_a: assert property (
		(ce && !r.ctrl[`ADTC_STANDBY_SELECT] && r.state == adtc_pkg::ST_XS
		&& cv.done) |=> (touch_conversion_irq
		&& r.x_res == $past(cv.result)))
		else $error("x result or irq missing");
	y_store_a: assert property (
		(ce && !r.ctrl[`ADTC_STANDBY_SELECT] && r.state == adtc_pkg::ST_YS
		&& cv.done) |=> (touch_conversion_irq
		&& r.y_res == $past(cv.result)))
		else $error("y result or irq missing");
	auto_seq_a: assert property (
		(ce && !r.ctrl[`ADTC_STANDBY_SELECT] && r.state == adtc_pkg::ST_AX
		&& cv.done) |=> (r.state == adtc_pkg::ST_AY
		&& core_start && !touch_conversion_irq))
		else $error("auto sequence broke after x");
	x_switch_a: assert property (
		(r.state == adtc_pkg::ST_XS || r.state == adtc_pkg::ST_AX)
		|-> (!xplus_switch_n && xminus_switch && yplus_switch_n
		&& !yminus_switch)) else $error("x switch pattern wrong");
	y_switch_a: assert property (
		(r.state == adtc_pkg::ST_YS || r.state == adtc_pkg::ST_AY)
		|-> (xplus_switch_n && !xminus_switch && !yplus_switch_n
		&& yminus_switch && analogue_input == `ADTC_XP_CHAN))
		else $error("y switch pattern wrong");
	wait_pad_a: assert property (
		(ce && wait_md && n.state == adtc_pkg::ST_IDLE)
		|=> (!xplus_pullup_n && yminus_switch && !xminus_switch))
		else $error("wait pads wrong");
	switch_follow_a: assert property (
		(ce && !wait_md && n.state == adtc_pkg::ST_IDLE)
		|=> (yminus_switch == $past(r.touch[`ADTC_YM])
		&& xminus_switch == $past(r.touch[`ADTC_XM])))
		else $error("switch outputs ignore register");
	standby_hold_a: assert property (
		(ce && r.ctrl[`ADTC_STANDBY_SELECT])
		|=> ($stable(r.x_res) && $stable(r.y_res)))
		else $error("results changed in standby");
	start_clear_a: assert property (
		(ce && r.state == adtc_pkg::ST_IDLE && n.conv_start
		&& !(wr && addr == `ADTC_OFF_CTRL)) |=> !r.ctrl[`ADTC_START])
		else $error("start bit not cleared");
	read_start_a: assert property (
		(ce && rd && addr == `ADTC_OFF_DATA0 && r.ctrl[`ADTC_RDSTART])
		|=> r.rd_pend) else $error("read did not request start");
	pen_down_a: assert property (
		(ce && wait_md && !r.touch[`ADTC_UD] && r.pen_sync[1]
		&& !r.pen_sync[2]) |=> stylus_irq)
		else $error("pen-down irq missing");
	tc_pulse_a: assert property (
		(ce && touch_conversion_irq) |=> !touch_conversion_irq)
		else $error("conversion irq longer than one cycle");
	sty_pulse_a: assert property (
		(ce && stylus_irq) |=> !stylus_irq)
		else $error("stylus irq longer than one cycle");
	pen_up_a: assert property (
		(ce && wait_md && r.touch[`ADTC_UD] && !r.pen_sync[1]
		&& r.pen_sync[2]) |=> stylus_irq)
		else $error("pen-up irq missing");

	auto_done_c: cover property (
		r.state == adtc_pkg::ST_AY ##1 touch_conversion_irq);
	stylus_c: cover property (stylus_irq);
	read_start_c: cover property (r.rd_pend ##1 core_start);
endmodule
